// File: hdl/rstseq_top.sv
// reset initialization sequencer: power-on capture, hard/soft reset flow, boot pin turnaround
// assumes pins are asynchronous to ref_clk; open-drain outputs drive low while oe is high;
// the sync clock (or the primary clock in host mode, divided inside when strapped) arrives as an ordinary pin
//
// Contract
// RULE1 - requester holds hard/soft input 32 sync periods
// RULE2 - agent mode power-on held 32 sync periods
// RULE3 - driven hard/soft outputs held 512 periods
// RULE4 - soft release lags hard release 16 periods
// RULE5 - host mode straps valid 4 primary periods
// RULE6 - agent mode straps valid 4 sync periods
// RULE7 - straps stable until hard reset release
// RULE8 - stop driving boot pins within 4 ns
// RULE9 - redrive boot pins one period after release
// RULE10 - host mode counts use divided primary clock
// RULE11 - wait for clock lock before release (code stops waiting after PLL_WAIT + DLL_WAIT ref_clk cycles, locked or not)
// RULE12 - host mode power-on held 32 primary periods
`timescale 1ns/10ps
module rstseq_top
    import rstseq_pkg::*;
#(
    parameter int unsigned PLL_WAIT = PLL_LOCK_CYC,   // shorten for simulation
    parameter int unsigned DLL_WAIT = DLL_LOCK_MAX    // ref_clk cycles allowed for DLL lock
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    input  wire logic                 power_on_reset_n,
    input  wire logic                 host_mode,
    input  wire logic                 sync_clk_in,
    input  wire logic                 primary_clock_in,
    input  wire logic                 hard_reset_n_in,
    input  wire logic                 soft_reset_n_in,
    input  wire logic                 hard_req,
    input  wire logic                 soft_req,
    input  wire logic                 pll_locked,
    input  wire logic                 dll_locked,
    input  wire rstseq_cfg_t          cfg_pin_in,
    output logic                      hard_reset_n_out,
    output logic                      hard_reset_n_oe,
    output logic                      soft_reset_n_out,
    output logic                      soft_reset_n_oe,
    output rstseq_cfg_t               cfg_pin_out,
    output logic                      cfg_pin_oe,
    output rstseq_cfg_t               boot_cfg,
    output logic                      core_reset_n
);

    // two-flop synchronisers for every pin; stage one is read only by stage two
    logic [7:0] meta_q, sync_q;
    logic [3:0] cfg_meta_q, cfg_sync_q;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q     <= 8'h00;
            sync_q     <= 8'h00;
            cfg_meta_q <= 4'h0;
            cfg_sync_q <= 4'h0;
        end else begin
            meta_q     <= {power_on_reset_n, host_mode, sync_clk_in, primary_clock_in,
                           hard_reset_n_in, soft_reset_n_in, 2'b00};
            sync_q     <= meta_q;
            cfg_meta_q <= cfg_pin_in;
            cfg_sync_q <= cfg_meta_q;
        end
    end

    logic por_n_s, host_s, syncclk_s, primclk_s, hard_in_s, soft_in_s;
    assign por_n_s   = sync_q[7];
    assign host_s    = sync_q[6];
    assign syncclk_s = sync_q[5];
    assign primclk_s = sync_q[4];
    assign hard_in_s = sync_q[3];
    assign soft_in_s = sync_q[2];

    // rising-edge enables from the sampled clocks; host mode divides primary clock when the strap asks for it
    logic sclk_d1_q, pclk_d1_q, pdiv_q, pdiv_d, sclk_d1_d, pclk_d1_d;
    logic sync_tick, prim_tick, per_tick;
    always_comb begin
        sclk_d1_d = syncclk_s;
        pclk_d1_d = primclk_s;
        prim_tick = primclk_s & ~pclk_d1_q;
        // divide-by-two when the strap asks for it, else pass through
        pdiv_d    = prim_tick ? ~pdiv_q : pdiv_q;
        sync_tick = syncclk_s & ~sclk_d1_q;
        per_tick  = host_s ? (prim_tick & (~boot_cfg.input_clock_divide_cfg | pdiv_q)) // RULE10
                           : sync_tick;
    end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sclk_d1_q <= 1'b0;
            pclk_d1_q <= 1'b0;
            pdiv_q    <= 1'b0;
        end else begin
            sclk_d1_q <= sclk_d1_d;
            pclk_d1_q <= pclk_d1_d;
            pdiv_q    <= pdiv_d;
        end
    end

    // saturating period counter step, used by both request filters
    function automatic logic [9:0] sat_inc(input logic [9:0] v, input logic tick);
        sat_inc = (tick && v != 10'h03FF) ? v + CNT_ONE : v;
    endfunction : sat_inc

    // input request filters: an external low only counts once held 32 periods
    logic [9:0] hreq_cnt_q, hreq_cnt_d, sreq_cnt_q, sreq_cnt_d;
    logic       hard_ext, soft_ext;
    always_comb begin
        // own drive clears the count, else our release would read back as a request
        hreq_cnt_d = (hard_in_s | hard_reset_n_oe) ? 10'h000 : sat_inc(hreq_cnt_q, per_tick);
        sreq_cnt_d = (soft_in_s | soft_reset_n_oe) ? 10'h000 : sat_inc(sreq_cnt_q, per_tick);
        hard_ext   = (hreq_cnt_q >= REQ_MIN_PER) & ~hard_reset_n_oe;   // RULE1
        soft_ext   = (sreq_cnt_q >= REQ_MIN_PER) & ~soft_reset_n_oe;   // RULE1
    end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hreq_cnt_q <= 10'h000;
            sreq_cnt_q <= 10'h000;
        end else begin
            hreq_cnt_q <= hreq_cnt_d;
            sreq_cnt_q <= sreq_cnt_d;
        end
    end

    // main sequencer; power-on low forces everything back to the start
    rstseq_state_t state_q, state_d;
    logic [9:0]        cnt_q, cnt_d;
    logic [LOCK_W-1:0] lock_q, lock_d;
    rstseq_cfg_t       boot_q, boot_d;
    logic              hard_oe_q, hard_oe_d, soft_oe_q, soft_oe_d, cfg_oe_q, cfg_oe_d;
    logic              core_q, core_d;

    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        lock_d    = lock_q;
        boot_d    = boot_q;
        hard_oe_d = hard_oe_q;
        soft_oe_d = soft_oe_q;
        cfg_oe_d  = cfg_oe_q;
        core_d    = core_q;
        if (!por_n_s) begin
            // straps are sampled continuously; last value before release wins
            state_d   = RSQ_POR;
            boot_d    = cfg_sync_q;                                    // RULE5 RULE6
            hard_oe_d = 1'b1;
            soft_oe_d = 1'b1;
            cfg_oe_d  = 1'b0;
            core_d    = 1'b0;
            cnt_d     = 10'h000;
            lock_d    = '0;
        end else begin
            case (state_q)
                RSQ_POR: begin
                    // power-on length is the board's duty in either mode
                    state_d = RSQ_LOCK;                                // RULE2 RULE12
                    lock_d  = '0;
                end
                RSQ_LOCK: begin
                    // bounded waits so a dead lock indicator cannot hang the part
                    lock_d = lock_q + 24'h00_0001;
                    if ((pll_locked && dll_locked) ||
                        lock_q >= LOCK_W'(PLL_WAIT + DLL_WAIT)) begin  // RULE11
                        state_d = RSQ_DRIVE;
                        cnt_d   = 10'h000;
                    end
                end
                RSQ_DRIVE: begin
                    hard_oe_d = 1'b1;
                    soft_oe_d = 1'b1;
                    cfg_oe_d  = 1'b0;                                  // RULE8
                    core_d    = 1'b0;
                    cnt_d     = sat_inc(cnt_q, per_tick);
                    // hold both outputs 512 periods; our own drive keeps the pin low and masks hard_ext, so an external request does not extend it
                    if (cnt_q >= DRIVE_MIN_PER && hard_in_s == 1'b0 && !hard_ext) begin  // RULE3
                        hard_oe_d = 1'b0;
                        state_d   = RSQ_SOFT;
                        cnt_d     = 10'h000;
                    end
                end
                RSQ_SOFT: begin
                    cnt_d = sat_inc(cnt_q, per_tick);
                    // boot pins come back after one full period, straps held to here
                    if (cnt_q >= CFG_TURNON_PER)
                        cfg_oe_d = 1'b1;                               // RULE7 RULE9
                    if (cnt_q >= SOFT_LAG_PER && cnt_q >= CFG_TURNON_PER) begin // RULE4
                        soft_oe_d = 1'b0;
                        core_d    = 1'b1;
                        state_d   = RSQ_RUN;
                    end
                end
                RSQ_SOFTONL: begin
                    // soft-only reset keeps hard reset and boot pins untouched
                    soft_oe_d = 1'b1;
                    core_d    = 1'b0;
                    cnt_d     = sat_inc(cnt_q, per_tick);
                    if (cnt_q >= DRIVE_MIN_PER) begin                  // RULE3
                        soft_oe_d = 1'b0;
                        core_d    = 1'b1;
                        state_d   = RSQ_RUN;
                    end
                end
                RSQ_RUN: begin
                    // hard outranks soft when both arrive together
                    if (hard_ext || hard_req) begin
                        state_d   = RSQ_DRIVE;
                        hard_oe_d = 1'b1;
                        soft_oe_d = 1'b1;
                        cfg_oe_d  = 1'b0;                              // RULE8
                        core_d    = 1'b0;
                        cnt_d     = 10'h000;
                    end else if (soft_ext || soft_req) begin
                        state_d   = RSQ_SOFTONL;
                        soft_oe_d = 1'b1;
                        core_d    = 1'b0;
                        cnt_d     = 10'h000;
                    end
                end
                default: begin
                    state_d = RSQ_POR;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q   <= RSQ_POR;
            cnt_q     <= 10'h000;
            lock_q    <= '0;
            boot_q    <= '0;
            hard_oe_q <= 1'b1;
            soft_oe_q <= 1'b1;
            cfg_oe_q  <= 1'b0;
            core_q    <= 1'b0;
        end else begin
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            lock_q    <= lock_d;
            boot_q    <= boot_d;
            hard_oe_q <= hard_oe_d;
            soft_oe_q <= soft_oe_d;
            cfg_oe_q  <= cfg_oe_d;
            core_q    <= core_d;
        end
    end

    // open-drain: value is always low, enable decides; config pins echo the latched straps
    assign hard_reset_n_out = 1'b0;
    assign soft_reset_n_out = 1'b0;
    assign hard_reset_n_oe  = hard_oe_q;
    assign soft_reset_n_oe  = soft_oe_q;
    assign cfg_pin_out      = boot_q;
    assign cfg_pin_oe       = cfg_oe_q;
    assign boot_cfg         = boot_q;
    assign core_reset_n     = core_q;

endmodule : rstseq_top

// File: hdl/rstseq_pkg.sv
// package for the reset initialization sequencer: timing counts and carriers
// assumes a single 200 MHz ref_clk; sync clock and primary clock arrive as pins
package rstseq_pkg;

    // clock rate of ref_clk
    localparam int unsigned CLK_MHZ        = 200;
    localparam int unsigned CLK_PERIOD_PS  = 5000;

    // counts in sync-clock periods (edges seen on the sampled sync pin), in primary clock periods in host mode, two per count when the divide strap is set
    localparam logic [9:0] REQ_MIN_PER     = 10'h0020;  // 32 periods
    localparam logic [9:0] DRIVE_MIN_PER   = 10'h0200;  // 512 periods
    localparam logic [9:0] SOFT_LAG_PER    = 10'h0010;  // 16 periods
    localparam logic [9:0] CFG_TURNON_PER  = 10'h0001;  // 1 period
    localparam logic [9:0] CNT_ONE         = 10'h0001;

    // release of boot pins after hard reset assertion, in ns and in cycles
    localparam int unsigned CFG_OFF_NS     = 4;
    // longest time rounds down, but never below one cycle
    localparam int unsigned CFG_OFF_CYC_RAW = (CFG_OFF_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned CFG_OFF_CYC    = (CFG_OFF_CYC_RAW < 1) ? 1 : CFG_OFF_CYC_RAW;

    // clock lock waits
    localparam int unsigned PLL_LOCK_US    = 100;
    localparam int unsigned PLL_LOCK_CYC   = PLL_LOCK_US * CLK_MHZ;   // 20000 cycles
    localparam int unsigned DLL_LOCK_MIN   = 7680;     // system-bus clocks at 2:1
    localparam int unsigned DLL_LOCK_MAX   = 122880;   // system-bus clocks at 8:1

    // widths
    localparam int unsigned RSRC_W         = 3;
    localparam int unsigned LOCK_W         = 24;

    // sequencer states
    typedef enum logic [2:0] {
        RSQ_POR     = 3'b000,
        RSQ_LOCK    = 3'b001,
        RSQ_RUN     = 3'b010,
        RSQ_DRIVE   = 3'b011,
        RSQ_SOFT    = 3'b100,
        RSQ_SOFTONL = 3'b101
    } rstseq_state_t;

    // boot configuration captured at power-on release
    typedef struct packed {
        logic [RSRC_W-1:0] reset_source;
        logic              input_clock_divide_cfg;
    } rstseq_cfg_t;

    // the two open-drain reset pins, seen from the device
    typedef struct packed {
        logic hard_oe;
        logic soft_oe;
    } rstseq_pin_oe_t;

endpackage : rstseq_pkg

// File: tb/rstseq_board.sv
// board model: free-running sync and primary clocks, straps, pulled-up reset wires
// assumes the bench supplies strap values and the board's own reset pulls
`timescale 1ns/10ps
module rstseq_board
    import rstseq_pkg::*;
(
    input  wire logic        hard_reset_n_oe,
    input  wire logic        soft_reset_n_oe,
    input  wire logic        board_hard_pull,
    input  wire logic        board_soft_pull,
    input  wire rstseq_cfg_t strap,
    input  wire rstseq_cfg_t cfg_pin_out,
    input  wire logic        cfg_pin_oe,
    output logic             sync_clk_in,
    output logic             primary_clock_in,
    output logic             hard_reset_n_in,
    output logic             soft_reset_n_in,
    output rstseq_cfg_t      cfg_pin_in
);
    // 10 ns clocks, phase unrelated to ref_clk and to each other
    initial begin
        sync_clk_in = 1'h0;
        #1.3;
        forever #5 sync_clk_in = ~sync_clk_in;
    end
    initial begin
        primary_clock_in = 1'h0;
        #2.7;
        forever #5 primary_clock_in = ~primary_clock_in;
    end
    // pull-ups: a wire is low while any party pulls it
    assign hard_reset_n_in = ~(hard_reset_n_oe | board_hard_pull);
    assign soft_reset_n_in = ~(soft_reset_n_oe | board_soft_pull);
    // straps only show once the device lets go, held until release
    assign cfg_pin_in = cfg_pin_oe ? cfg_pin_out : strap;
endmodule : rstseq_board

// File: tb/rstseq_properties.sv
// checker: pin timing of the reset sequencer, from top ports only
// assumes free-running clock pins; bound to rstseq_top at the foot
`timescale 1ns/10ps
module rstseq_checker
    import rstseq_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        host_mode,
    input wire logic        sync_clk_in,
    input wire logic        primary_clock_in,
    input wire logic        hard_req,
    input wire logic        hard_reset_n_out,
    input wire logic        hard_reset_n_oe,
    input wire logic        soft_reset_n_out,
    input wire logic        soft_reset_n_oe,
    input wire logic        cfg_pin_oe,
    input wire rstseq_cfg_t boot_cfg,
    input wire logic        core_reset_n
);
    logic        sync_q, prim_q, tick;
    logic [10:0] k, hcnt_q, hcnt_d, scnt_q, scnt_d, lcnt_q, lcnt_d;
    // period ticks; one period of slack covers the design's pin synchroniser
    always_comb begin
        tick   = host_mode ? (primary_clock_in & ~prim_q) : (sync_clk_in & ~sync_q);
        k      = (host_mode & boot_cfg.input_clock_divide_cfg) ? 11'h002 : 11'h001;
        hcnt_d = hard_reset_n_oe ? hcnt_q + {10'h000, tick & ~&hcnt_q} : 11'h000;
        scnt_d = soft_reset_n_oe ? scnt_q + {10'h000, tick & ~&scnt_q} : 11'h000;
        lcnt_d = hard_reset_n_oe ? 11'h000 : lcnt_q + {10'h000, tick & ~&lcnt_q};
    end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            {sync_q, prim_q, hcnt_q, scnt_q, lcnt_q} <= '0;
        end else begin
            {sync_q, prim_q, hcnt_q, scnt_q, lcnt_q} <= {sync_clk_in, primary_clock_in, hcnt_d, scnt_d, lcnt_d};
        end
    end
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    out_level_a: assert property (!hard_reset_n_out && !soft_reset_n_out)
        else $error("reset pin drive value not low");
    pair_rise_a: assert property ($rose(hard_reset_n_oe) |-> soft_reset_n_oe && !cfg_pin_oe)
        else $error("hard assert without soft or with boot pins driven");
    cfg_off_a: assert property (hard_reset_n_oe |-> !cfg_pin_oe)
        else $error("boot pins driven during hard reset");
    hard_hold_a: assert property ($fell(hard_reset_n_oe) |-> hcnt_q >= 11'h1FF * k)
        else $error("hard reset driven too briefly");
    soft_hold_a: assert property ($fell(soft_reset_n_oe) |-> scnt_q >= 11'h1FF * k)
        else $error("soft reset driven too briefly");
    soft_lag_a: assert property ($fell(soft_reset_n_oe) |-> !hard_reset_n_oe && lcnt_q >= 11'h00F * k)
        else $error("soft released too soon after hard");
    cfg_turnon_a: assert property ($fell(hard_reset_n_oe) |-> !cfg_pin_oe [*2])
        else $error("boot pins redriven too soon");
    core_release_a: assert property ($rose(core_reset_n) |-> !soft_reset_n_oe && !hard_reset_n_oe)
        else $error("core released while reset pins held");
    hard_answer_a: assert property (core_reset_n && hard_req |=> hard_reset_n_oe && soft_reset_n_oe)
        else $error("hard request not answered next cycle");
    cover property ($fell(hard_reset_n_oe) && !host_mode);
    cover property ($fell(soft_reset_n_oe) && lcnt_q >= 11'h100);
    cover property ($fell(hard_reset_n_oe) && host_mode);
endmodule : rstseq_checker
bind rstseq_top rstseq_checker rstseq_checker_i (.ref_clk, .rstn, .host_mode, .sync_clk_in, .primary_clock_in,
    .hard_req, .hard_reset_n_out, .hard_reset_n_oe, .soft_reset_n_out, .soft_reset_n_oe, .cfg_pin_oe,
    .boot_cfg, .core_reset_n);

// File: tb/tb_reset_init_sequencer.sv
// bench: power-on and hard-request flows in agent and host mode, soft-request and pin-driven flows in agent mode only
// assumes 10 ns board clocks and shortened lock waits
`timescale 1ns/10ps
module tb_reset_init_sequencer
    import rstseq_pkg::*;
;
    logic        ref_clk = 1'h0, rstn = 1'h0, power_on_reset_n = 1'h0, host_mode = 1'h0;
    logic        hard_req = 1'h0, soft_req = 1'h0, pll_locked = 1'h0, dll_locked = 1'h0;
    logic        board_hard_pull = 1'h0, board_soft_pull = 1'h0;
    rstseq_cfg_t strap = 4'h0;
    logic        sync_clk_in, primary_clock_in, hard_reset_n_in, soft_reset_n_in, cfg_pin_oe;
    logic        hard_reset_n_out, hard_reset_n_oe, soft_reset_n_out, soft_reset_n_oe, core_reset_n;
    rstseq_cfg_t cfg_pin_in, cfg_pin_out, boot_cfg;
    int          n_errors = 0;
    int          cmp_count = 0;
    always #2.5 ref_clk = ~ref_clk;
    rstseq_top #(.PLL_WAIT(20), .DLL_WAIT(20)) rstseq_top_i (.ref_clk, .rstn, .power_on_reset_n, .host_mode,
        .sync_clk_in, .primary_clock_in, .hard_reset_n_in, .soft_reset_n_in, .hard_req, .soft_req, .pll_locked,
        .dll_locked, .cfg_pin_in, .hard_reset_n_out, .hard_reset_n_oe, .soft_reset_n_out, .soft_reset_n_oe,
        .cfg_pin_out, .cfg_pin_oe, .boot_cfg, .core_reset_n);
    rstseq_board rstseq_board_i (.hard_reset_n_oe, .soft_reset_n_oe, .board_hard_pull, .board_soft_pull, .strap,
        .cfg_pin_out, .cfg_pin_oe, .sync_clk_in, .primary_clock_in, .hard_reset_n_in, .soft_reset_n_in,
        .cfg_pin_in);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask : check
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    // time one flow in ref_clk cycles; per is cycles per counting period, pre cycles already seen driven
    task automatic t_flow(input logic hard, input int per, input int pre);
        int h, s;
        h = pre;
        s = hard ? 0 : pre;
        while (hard_reset_n_oe === 1'h1 && h < 20000) begin @(posedge ref_clk); #1; h++; end
        if (hard) check(cfg_pin_oe, 1'h0, "boot pins driven at hard release");
        while (soft_reset_n_oe === 1'h1 && s < 20000) begin @(posedge ref_clk); #1; s++; end
        check(hard ? h >= 511 * per : s >= 511 * per, 1'h1, "drive too short");
        if (hard) check(s >= 15 * per, 1'h1, "soft lag too short");
        check(core_reset_n, 1'h1, "core not released");
        check(cfg_pin_oe, 1'h1, "boot pins not redriven");
    endtask : t_flow
    task automatic t_power_on(input logic host, input logic div, input int per);
        @(posedge ref_clk);
        {power_on_reset_n, host_mode, pll_locked, dll_locked} <= {1'h0, host, 2'h0};
        strap <= {host ? 3'h2 : 3'h5, div};
        repeat (40 * per) @(posedge ref_clk);
        power_on_reset_n <= 1'h1;
        repeat (10) @(posedge ref_clk);
        #1;
        check(hard_reset_n_oe, 1'h1, "hard released before lock");
        @(posedge ref_clk);
        {pll_locked, dll_locked} <= 2'h3;
        t_flow(1'h1, per, 0);
        check(boot_cfg, strap, "straps not latched");
        check(cfg_pin_out, strap, "boot pins redrive wrong value");
        $display("done power-on host=%0d", host);
    endtask : t_power_on
    task automatic t_req(input logic hard, input int per);
        @(posedge ref_clk);
        {hard_req, soft_req} <= {hard, ~hard};
        @(posedge ref_clk);
        {hard_req, soft_req} <= 2'h0;
        #1;
        check(soft_reset_n_oe, 1'h1, "soft pin not pulled");
        check(hard_reset_n_oe, hard, "hard pin state");
        check(cfg_pin_oe, !hard, "boot pin drive at hard assert");
        t_flow(hard, per, 0);
        $display("done request hard=%0d", hard);
    endtask : t_req
    // board pulls one reset wire for len periods; shorter than 32 is ignored
    // cycles driven during the pull and the 10 cycles after it are counted, the flow starts mid-pull
    task automatic t_pin(input int len, input logic hard);
        int i, on;
        on = 0;
        @(posedge ref_clk);
        {board_hard_pull, board_soft_pull} <= {hard, !hard};
        for (i = 0; i < len * 2 + 10; i++) begin
            @(posedge ref_clk);
            if (i == len * 2 - 1) begin
                {board_hard_pull, board_soft_pull} <= 2'h0;
            end
            #1;
            on += int'(hard ? hard_reset_n_oe === 1'h1 : soft_reset_n_oe === 1'h1);
        end
        check(hard ? hard_reset_n_oe : soft_reset_n_oe, len >= 32, "pin request handling");
        if (len >= 32) t_flow(hard, 2, on);
        $display("done pin pull %0d hard=%0d", len, hard);
    endtask : t_pin
    initial begin
        repeat (4) @(posedge ref_clk);
        rstn <= 1'h1;
        t_power_on(1'h0, 1'h0, 2);
        t_req(1'h1, 2);
        t_req(1'h0, 2);
        t_pin(20, 1'h1);
        t_pin(40, 1'h1);
        t_pin(40, 1'h0);
        t_power_on(1'h1, 1'h1, 4);
        t_req(1'h1, 4);
        end_sim();
    end
    // about 10000 cycles expected; four times that means a hang
    initial begin
        repeat (40000) @(posedge ref_clk);
        n_errors++;
        end_sim();
    end
endmodule : tb_reset_init_sequencer
